/* File: include/aoms_regs.vh */
`ifndef AOMS_REGS_VH
`define AOMS_REGS_VH

// register byte offsets
`define AOMS_ADDR_CTRL      8'h00
`define AOMS_ADDR_ASLP      8'h04
`define AOMS_ADDR_STATUS    8'h08

// control register fields
`define AOMS_CTRL_ACTIVE    0
`define AOMS_CTRL_HIB_EN    1
`define AOMS_CTRL_FUNC_LO   2
`define AOMS_CTRL_FUNC_HI   3
`define AOMS_CTRL_ROUTE2    4
`define AOMS_CTRL_RST       8'h00
`define AOMS_ASLP_RST       8'h00
`define AOMS_FUNC_TRIG      2'h1

// status register fields
`define AOMS_STAT_MODE_LO   0
`define AOMS_STAT_MODE_HI   2
`define AOMS_STAT_BOOTDONE  3
`define AOMS_STAT_STRAP     4
`define AOMS_STAT_ANALOG    5

// timing, clock in MHz, other figures in microseconds
`define AOMS_CLK_MHZ        200
`define AOMS_T_BOOT_A_US    1000
`define AOMS_T_BOOT_B_US    2000
`define AOMS_T_PULSE_A_US   10
`define AOMS_T_PULSE_B_US   10
`define AOMS_T_MOT_HIB_US   20000

`endif

/* File: verilog/aoms_sync.v */
`timescale 1ns/10ps
module aoms_sync
#(
    parameter W = 1
)
(
    input  wire         clk_in,
    input  wire         srst_in,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] stable_out
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    reg [W-1:0] stable_ff;
    integer     i;

    // a bit moves only once the second and third stages agree
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            s1_ff     <= {W{1'b0}};
            s2_ff     <= {W{1'b0}};
            s3_ff     <= {W{1'b0}};
            stable_ff <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1)
            begin
                if (s2_ff[i] == s3_ff[i])
                    stable_ff[i] <= s3_ff[i];
            end
        end
    end

    assign stable_out = stable_ff;
endmodule

/* File: verilog/aoms_timer.v */
`timescale 1ns/10ps
module aoms_timer
(
    input  wire        clk_in,
    input  wire        srst_in,
    input  wire        start_in,
    input  wire        abort_in,
    input  wire [23:0] len_in,
    output wire        busy_out,
    output wire        done_out
);
    reg [23:0] cnt_ff;
    reg        busy_ff;
    reg        done_ff;

    // done is a one-cycle pulse len_in cycles after start
    always @(posedge clk_in)
    begin
        if (srst_in || abort_in)
        begin
            cnt_ff  <= 24'h000000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else if (start_in)
        begin
            cnt_ff  <= len_in;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end
        else if (busy_ff)
        begin
            cnt_ff  <= cnt_ff - 24'h000001;
            done_ff <= (cnt_ff == 24'h000001);
            busy_ff <= (cnt_ff != 24'h000001);
        end
        else
            done_ff <= 1'b0;
    end

    assign busy_out = busy_ff;
    assign done_out = done_ff;
endmodule

/* File: verilog/aoms_seq.v */
// Notes on behaviour
// - boot on supply good; bus dead while off
// - strap low: load defaults, flag, pulse pin one
// - strap high: also load motion parameters
// - strap high: boot pulse only on pin two
// - hibernate keeps only wake-up detection alive
// - hibernate: no bus answer, registers discarded
// - strap high: motion pin high level wakes
// - strap high: bus only after boot completes
// - standby: analog off, bus answers
// - active: analog on demand, bus available
// - strap low: nonzero count enables auto sleep
// - strap high: auto sleep off unless configured
// - strap low: trigger function, rising pin two starts measurement
// - measurement done returns to trigger wait
// - trigger mode keeps bus answering
// - leaving active keeps registers intact, except a motion-low exit, which clears the active bit
// - strap low: active bit enters wake
// - strap low: hibernate bit enters hibernate
// - strap high: active set after boot if the motion pin is high
`timescale 1ns/10ps
`include "aoms_regs.vh"
module aoms_seq
#(
    parameter [23:0] BOOT_A_CYC  = `AOMS_T_BOOT_A_US * `AOMS_CLK_MHZ,
    parameter [23:0] BOOT_B_CYC  = `AOMS_T_BOOT_B_US * `AOMS_CLK_MHZ,
    parameter [23:0] MOT_HIB_CYC = `AOMS_T_MOT_HIB_US * `AOMS_CLK_MHZ
)
(
    input  wire       clk_in,
    input  wire       srst_in,
    input  wire       supply_ok_in,
    input  wire       boot_strap_select_in,
    input  wire       wake_pin_in,
    input  wire       motion_detect_pin_in,
    input  wire       irq_pin_two_in,
    input  wire       meas_done_in,
    input  wire       activity_in,
    input  wire       inactivity_in,
    input  wire [7:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output wire [7:0] rdata_out,
    output wire [2:0] mode_out,
    output wire       bus_avail_out,
    output wire       analog_en_out,
    output wire       wake_det_en_out,
    output wire       otp_load_out,
    output wire       otp_motion_load_out,
    output wire       meas_start_out,
    output wire       irq_pin_one_out,
    output wire       irq_pin_two_out,
    output wire       irq_pin_two_oe_n_out
);
    localparam [2:0] M_OFF   = 3'h0;
    localparam [2:0] M_BOOT  = 3'h1;
    localparam [2:0] M_STBY  = 3'h2;
    localparam [2:0] M_HIB   = 3'h3;
    localparam [2:0] M_WAKE  = 3'h4;
    localparam [2:0] M_SLEEP = 3'h5;
    localparam [2:0] M_TRIGW = 3'h6;
    localparam [2:0] M_TRIGM = 3'h7;

    localparam [23:0] PULSE_A_CYC = `AOMS_T_PULSE_A_US * `AOMS_CLK_MHZ;
    localparam [23:0] PULSE_B_CYC = `AOMS_T_PULSE_B_US * `AOMS_CLK_MHZ;

    wire [4:0] pins_sync;
    wire       supply_ok;
    wire       strap_pin;
    wire       wake_pin;
    wire       motion_pin;
    wire       trig_pin;
    wire       boot_busy;
    wire       boot_done;
    wire       pulse_done;

    reg  [2:0] mode_ff;
    reg        strap_ff;
    reg  [7:0] ctrl_ff;
    reg  [7:0] aslp_ff;
    reg  [7:0] inact_cnt_ff;
    reg  [23:0] mot_low_cnt_ff;
    reg        boot_done_ff;
    reg        wake_last_ff;
    reg        trig_last_ff;
    reg        boot_start_ff;
    reg        pulse_start_ff;
    reg        bus_avail_ff;
    reg        analog_en_ff;
    reg        wake_det_en_ff;
    reg        otp_load_ff;
    reg        otp_motion_ff;
    reg        meas_start_ff;
    reg        pin_one_ff;
    reg        pin_two_ff;
    reg        pin_two_oe_n_ff;
    reg  [7:0] rdata_ff;

    reg  [2:0] nxt_mode;
    reg        nxt_active;
    reg        clr_regs;
    reg        go_boot;
    reg        mot_low_long;
    reg        aslp_on;
    reg        trig_func;

    // bus answers only outside off, boot and hibernate
    function bus_ok;
        input [2:0] m;
        begin
            bus_ok = (m != M_OFF) && (m != M_BOOT) && (m != M_HIB);
        end
    endfunction

    // measuring modes, where analog may be powered on demand
    function meas_mode;
        input [2:0] m;
        begin
            meas_mode = (m == M_WAKE) || (m == M_SLEEP) ||
                        (m == M_TRIGM);
        end
    endfunction

    aoms_sync #(
        .W          (5)
    ) u_sync (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .async_in   ({irq_pin_two_in, motion_detect_pin_in,
                      wake_pin_in, boot_strap_select_in,
                      supply_ok_in}),
        .stable_out (pins_sync)
    );

    assign supply_ok  = pins_sync[0];
    assign strap_pin  = pins_sync[1];
    assign wake_pin   = pins_sync[2];
    assign motion_pin = pins_sync[3];
    assign trig_pin   = pins_sync[4];

    // boot length follows the strap seen at boot start
    aoms_timer u_boot_tmr (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .start_in   (boot_start_ff),
        .abort_in   (!supply_ok),
        .len_in     (strap_ff ? BOOT_B_CYC : BOOT_A_CYC),
        .busy_out   (boot_busy),
        .done_out   (boot_done)
    );

    aoms_timer u_pulse_tmr (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .start_in   (pulse_start_ff),
        .abort_in   (!supply_ok),
        .len_in     (strap_ff ? PULSE_B_CYC : PULSE_A_CYC),
        .busy_out   (),
        .done_out   (pulse_done)
    );

    always @*
    begin
        trig_func = (ctrl_ff[`AOMS_CTRL_FUNC_HI:`AOMS_CTRL_FUNC_LO]
                     == `AOMS_FUNC_TRIG) && !strap_ff;
        // same register both ways; strap high just keeps reset zero
        aslp_on = (aslp_ff != 8'h00);
        mot_low_long = strap_ff && (mot_low_cnt_ff >= MOT_HIB_CYC);
        nxt_mode   = mode_ff;
        nxt_active = ctrl_ff[`AOMS_CTRL_ACTIVE];
        clr_regs   = 1'b0;
        go_boot    = 1'b0;
        case (mode_ff)
            M_OFF:
            begin
                if (supply_ok)
                begin
                    nxt_mode = M_BOOT;
                    go_boot  = 1'b1;
                end
            end
            M_BOOT:
            begin
                if (boot_done)
                begin
                    if (strap_ff && motion_pin)
                    begin
                        nxt_active = 1'b1;
                        nxt_mode   = M_WAKE;
                    end
                    else
                        nxt_mode = M_STBY;
                end
            end
            M_STBY:
            begin
                if (!strap_ff && ctrl_ff[`AOMS_CTRL_HIB_EN])
                begin
                    nxt_mode = M_HIB;
                    clr_regs = 1'b1;
                end
                else if (mot_low_long)
                begin
                    nxt_mode = M_HIB;
                    clr_regs = 1'b1;
                end
                else if (trig_func)
                    nxt_mode = M_TRIGW;
                else if (ctrl_ff[`AOMS_CTRL_ACTIVE])
                    nxt_mode = M_WAKE;
            end
            M_HIB:
            begin
                // strap low: any stable change of the wake pin
                if (!strap_ff && (wake_pin != wake_last_ff))
                begin
                    nxt_mode = M_BOOT;
                    go_boot  = 1'b1;
                end
                else if (strap_ff && motion_pin)
                begin
                    nxt_mode = M_BOOT;
                    go_boot  = 1'b1;
                end
            end
            M_WAKE, M_SLEEP:
            begin
                if (mot_low_long)
                begin
                    nxt_active = 1'b0;
                    nxt_mode   = M_STBY;
                end
                else if (!ctrl_ff[`AOMS_CTRL_ACTIVE])
                    nxt_mode = M_STBY;
                else if (trig_func)
                    nxt_mode = M_TRIGW;
                else if (mode_ff == M_WAKE && aslp_on &&
                         inactivity_in &&
                         inact_cnt_ff + 8'h01 >= aslp_ff)
                    nxt_mode = M_SLEEP;
                else if (mode_ff == M_SLEEP && activity_in)
                    nxt_mode = M_WAKE;
            end
            M_TRIGW:
            begin
                if (!trig_func)
                    nxt_mode = M_STBY;
                else if (trig_pin && !trig_last_ff)
                    nxt_mode = M_TRIGM;
            end
            M_TRIGM:
            begin
                if (meas_done_in)
                    nxt_mode = M_TRIGW;
            end
            default:
                nxt_mode = M_OFF;
        endcase
    end

    always @(posedge clk_in)
    begin
        if (srst_in || !supply_ok)
        begin
            mode_ff         <= M_OFF;
            strap_ff        <= 1'b0;
            ctrl_ff         <= `AOMS_CTRL_RST;
            aslp_ff         <= `AOMS_ASLP_RST;
            inact_cnt_ff    <= 8'h00;
            mot_low_cnt_ff  <= 24'h000000;
            boot_done_ff    <= 1'b0;
            wake_last_ff    <= 1'b0;
            trig_last_ff    <= 1'b0;
            boot_start_ff   <= 1'b0;
            pulse_start_ff  <= 1'b0;
            bus_avail_ff    <= 1'b0;
            analog_en_ff    <= 1'b0;
            wake_det_en_ff  <= 1'b0;
            otp_load_ff     <= 1'b0;
            otp_motion_ff   <= 1'b0;
            meas_start_ff   <= 1'b0;
            pin_one_ff      <= 1'b0;
            pin_two_ff      <= 1'b0;
            pin_two_oe_n_ff <= 1'b0;
            rdata_ff        <= 8'h00;
        end
        else
        begin
            mode_ff      <= nxt_mode;
            trig_last_ff <= trig_pin;
            // the wake pin level is tracked only outside hibernate and held in hibernate as the reference
            if (mode_ff != M_HIB)
                wake_last_ff <= wake_pin;
            if (go_boot)
                strap_ff <= strap_pin;
            boot_start_ff <= go_boot;

            // motion pin low time, strap high only
            if (strap_ff && !motion_pin && bus_ok(mode_ff))
            begin
                if (mot_low_cnt_ff < MOT_HIB_CYC)
                    mot_low_cnt_ff <= mot_low_cnt_ff + 24'h000001;
            end
            else
                mot_low_cnt_ff <= 24'h000000;

            // register file: writes only where the bus answers
            if (clr_regs || go_boot)
            begin
                ctrl_ff      <= `AOMS_CTRL_RST;
                aslp_ff      <= `AOMS_ASLP_RST;
                boot_done_ff <= 1'b0;
            end
            else
            begin
                if (wr_in && bus_ok(mode_ff) &&
                    addr_in == `AOMS_ADDR_CTRL)
                    ctrl_ff <= {3'h0, wdata_in[4:0]};
                else
                    ctrl_ff[`AOMS_CTRL_ACTIVE] <= nxt_active;
                if (wr_in && bus_ok(mode_ff) &&
                    addr_in == `AOMS_ADDR_ASLP)
                    aslp_ff <= wdata_in;
                if (boot_done)
                    boot_done_ff <= 1'b1;
            end

            // inactivity run length, restarted on each wake entry
            if (nxt_mode != M_WAKE || mode_ff != M_WAKE)
                inact_cnt_ff <= 8'h00;
            else if (activity_in)
                inact_cnt_ff <= 8'h00;
            else if (inactivity_in && inact_cnt_ff != 8'hFF)
                inact_cnt_ff <= inact_cnt_ff + 8'h01;

            // read data stands one cycle after the strobe; dead bus reads 0
            rdata_ff <= 8'h00;
            if (rd_in && bus_ok(mode_ff))
            begin
                case (addr_in)
                    `AOMS_ADDR_CTRL:   rdata_ff <= ctrl_ff;
                    `AOMS_ADDR_ASLP:   rdata_ff <= aslp_ff;
                    `AOMS_ADDR_STATUS:
                        rdata_ff <= {2'h0, analog_en_ff, strap_ff,
                                     boot_done_ff, mode_ff};
                    default:           rdata_ff <= 8'h00;
                endcase
            end

            // boot loads
            otp_load_ff   <= (nxt_mode == M_BOOT) && !boot_done;
            otp_motion_ff <= (nxt_mode == M_BOOT) && !boot_done &&
                             (go_boot ? strap_pin : strap_ff);

            // boot pulse routing
            pulse_start_ff <= boot_done;
            if (boot_done)
            begin
                if (strap_ff || ctrl_ff[`AOMS_CTRL_ROUTE2])
                    pin_two_ff <= 1'b1;
                else
                    pin_one_ff <= 1'b1;
            end
            else if (pulse_done)
            begin
                pin_one_ff <= 1'b0;
                pin_two_ff <= 1'b0;
            end
            // pin two turns input only when it serves as trigger
            pin_two_oe_n_ff <= trig_func;

            // power gating
            bus_avail_ff   <= bus_ok(nxt_mode);
            wake_det_en_ff <= (nxt_mode == M_HIB);
            // analog powered only while a measurement may run
            analog_en_ff   <= meas_mode(nxt_mode);
            meas_start_ff  <= (mode_ff == M_TRIGW) &&
                              (nxt_mode == M_TRIGM);
        end
    end

    assign rdata_out            = rdata_ff;
    assign mode_out             = mode_ff;
    assign bus_avail_out        = bus_avail_ff;
    assign analog_en_out        = analog_en_ff;
    assign wake_det_en_out      = wake_det_en_ff;
    assign otp_load_out         = otp_load_ff;
    assign otp_motion_load_out  = otp_motion_ff;
    assign meas_start_out       = meas_start_ff;
    assign irq_pin_one_out      = pin_one_ff;
    assign irq_pin_two_out      = pin_two_ff;
    assign irq_pin_two_oe_n_out = pin_two_oe_n_ff;
endmodule

/* File: verification/aoms_seq_asserts.sv */
`timescale 1ns/10ps
module aoms_seq_chk
(
    input wire       clk_in,
    input wire       srst_in,
    input wire       supply_ok_in,
    input wire       boot_strap_select_in,
    input wire       meas_done_in,
    input wire       rd_in,
    input wire [7:0] rdata_out,
    input wire [2:0] mode_out,
    input wire       bus_avail_out,
    input wire       analog_en_out,
    input wire       wake_det_en_out,
    input wire       otp_load_out,
    input wire       otp_motion_load_out,
    input wire       meas_start_out,
    input wire       irq_pin_one_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    property p_bus;
        bus_avail_out == (mode_out == 3'h2 || mode_out >= 3'h4);
    endproperty
    a_bus: assert property (p_bus) else $error("bus availability wrong");
    property p_ana;
        analog_en_out == (mode_out == 3'h4 || mode_out == 3'h5 ||
                          mode_out == 3'h7);
    endproperty
    a_ana: assert property (p_ana) else $error("analog enable wrong");
    property p_hib;
        wake_det_en_out == (mode_out == 3'h3);
    endproperty
    a_hib: assert property (p_hib) else $error("wake detect enable wrong");
    property p_ref;
        rd_in && !bus_avail_out |=> rdata_out == 8'h00;
    endproperty
    a_ref: assert property (p_ref) else $error("read answered while off");
    // three sync stages, the agreement stage and the state register, no margin
    property p_off;
        !supply_ok_in [*6] |-> mode_out == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("not off without supply");
    property p_otp;
        otp_motion_load_out |-> otp_load_out && mode_out == 3'h1;
    endproperty
    a_otp: assert property (p_otp) else $error("motion load outside boot");
    property p_pin1;
        irq_pin_one_out |-> !boot_strap_select_in;
    endproperty
    a_pin1: assert property (p_pin1) else $error("pulse on pin one, strap high");
    property p_trg;
        meas_start_out |-> ##[0:2] mode_out == 3'h7;
    endproperty
    a_trg: assert property (p_trg) else $error("trigger without measurement");
    property p_ret;
        mode_out == 3'h7 && meas_done_in |-> ##[1:3] mode_out == 3'h6;
    endproperty
    a_ret: assert property (p_ret) else $error("no return to trigger wait");
endmodule

bind aoms_seq aoms_seq_chk chk_u
(
    .clk_in(clk_in), .srst_in(srst_in), .supply_ok_in(supply_ok_in),
    .boot_strap_select_in(boot_strap_select_in), .rd_in(rd_in),
    .meas_done_in(meas_done_in), .rdata_out(rdata_out),
    .mode_out(mode_out), .bus_avail_out(bus_avail_out),
    .analog_en_out(analog_en_out), .wake_det_en_out(wake_det_en_out),
    .otp_load_out(otp_load_out), .otp_motion_load_out(otp_motion_load_out),
    .meas_start_out(meas_start_out), .irq_pin_one_out(irq_pin_one_out)
);

/* File: verification/aoms_host_model.sv */
`timescale 1ns/10ps
module aoms_host_model
#(
    parameter DLY = 4
)
(
    input  wire clk_in,
    input  wire trig_in,
    input  wire pin_two_in,
    input  wire pin_two_oe_n_in,
    input  wire meas_start_in,
    output wire pin_line_out,
    output reg  meas_done_out = 1'b0
);
    integer cnt = 0;
    // host drives pin two only once the device lets go of it
    assign pin_line_out = pin_two_oe_n_in ? trig_in : pin_two_in;
    // a conversion takes DLY cycles, then a single done pulse
    always @(posedge clk_in)
    begin
        meas_done_out <= (cnt == 1);
        if (meas_start_in)
            cnt <= DLY;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`include "aoms_regs.vh"
module testbench;
    reg        clk_in = 1'b0;
    reg        srst_in = 1'b1;
    reg        supply = 1'b0;
    reg        strap = 1'b0;
    reg        wake = 1'b0;
    reg        motion = 1'b0;
    reg        trig = 1'b0;
    reg        act = 1'b0;
    reg        ina = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg        seen1 = 1'b0;
    reg        seen2 = 1'b0;
    reg        clr_seen = 1'b0;
    reg  [7:0] v;
    wire [7:0] rdata;
    wire [2:0] mode;
    wire       p1, p2, oe_n, line, mstart, mdone;
    integer    n_mismatch = 0;
    integer    checks = 0;
    integer    seed = 83137;
    integer    i, n, k;

    always #2.5 clk_in = ~clk_in;

    aoms_seq #(.BOOT_A_CYC(24'h000014), .BOOT_B_CYC(24'h000028),
               .MOT_HIB_CYC(24'h00001E)) dut_u
    (
        .clk_in(clk_in), .srst_in(srst_in), .supply_ok_in(supply),
        .boot_strap_select_in(strap), .wake_pin_in(wake),
        .motion_detect_pin_in(motion), .irq_pin_two_in(line),
        .meas_done_in(mdone), .activity_in(act), .inactivity_in(ina),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .mode_out(mode), .bus_avail_out(),
        .analog_en_out(), .wake_det_en_out(), .otp_load_out(),
        .otp_motion_load_out(), .meas_start_out(mstart),
        .irq_pin_one_out(p1), .irq_pin_two_out(p2),
        .irq_pin_two_oe_n_out(oe_n)
    );
    aoms_host_model host_u
    (
        .clk_in(clk_in), .trig_in(trig), .pin_two_in(p2),
        .pin_two_oe_n_in(oe_n), .meas_start_in(mstart),
        .pin_line_out(line), .meas_done_out(mdone)
    );

    // the boot pulse is long, so a sticky flag is enough to see it
    always @(posedge clk_in)
    begin
        if (clr_seen)
        begin
            seen1 <= 1'b0;
            seen2 <= 1'b0;
        end
        else
        begin
            if (p1 === 1'b1)
                seen1 <= 1'b1;
            if (p2 === 1'b1)
                seen2 <= 1'b1;
        end
    end

    function [7:0] stat(input [2:0] m, input s, input a);
        stat = {2'b00, a, s, 1'b1, m};
    endfunction

    task conclude;
    begin
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    end
    endtask

    task rd_chk(input string nm, input [7:0] a, input [7:0] e);
    begin
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    end
    endtask

    // bounded wait, the limit covers the longest boot and hibernate entry
    task wm(input string nm, input [2:0] m);
    begin
        k = 0;
        while (mode !== m && k < 20000)
        begin
            @(posedge clk_in);
            k = k + 1;
        end
        #1 chk(nm, {5'h00, m}, {5'h00, mode});
    end
    endtask

    task pls(input is_act);
    begin
        @(posedge clk_in);
        act <= is_act;
        ina <= !is_act;
        @(posedge clk_in);
        act <= 1'b0;
        ina <= 1'b0;
    end
    endtask

    initial
    begin
        // about 80k cycles, far above the few hundred the tests need
        #400000;
        n_mismatch = n_mismatch + 1;
        conclude;
    end

    initial
    begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rd_chk("off_status", `AOMS_ADDR_STATUS, 8'h00);
        supply <= 1'b1;
        wm("boot_a", 3'h2);
        repeat (5) @(posedge clk_in);
        rd_chk("stat_a", `AOMS_ADDR_STATUS, stat(3'h2, 1'b0, 1'b0));
        chk("pulse_one", 8'h01, {7'h00, seen1});
        chk("pulse_two", 8'h00, {7'h00, seen2});
        n = 1 + ($random(seed) & 3);
        wr_reg(`AOMS_ADDR_ASLP, n[7:0]);
        wr_reg(`AOMS_ADDR_CTRL, 8'h01);
        wm("wake", 3'h4);
        rd_chk("stat_w", `AOMS_ADDR_STATUS, stat(3'h4, 1'b0, 1'b1));
        for (i = 1; i < n; i = i + 1)
            pls(1'b0);
        repeat (3) @(posedge clk_in);
        chk("no_sleep", 8'h04, {5'h00, mode});
        pls(1'b0);
        wm("sleep", 3'h5);
        pls(1'b1);
        wm("rewake", 3'h4);
        wr_reg(`AOMS_ADDR_CTRL, 8'h00);
        wm("standby", 3'h2);
        rd_chk("aslp_kept", `AOMS_ADDR_ASLP, n[7:0]);
        wr_reg(`AOMS_ADDR_CTRL, 8'h04);
        wm("trig_wait", 3'h6);
        for (i = 0; i < 3; i = i + 1)
        begin
            rd_chk("stat_t", `AOMS_ADDR_STATUS, stat(3'h6, 1'b0, 1'b0));
            repeat (2 + ($random(seed) & 7)) @(posedge clk_in);
            trig <= 1'b1;
            wm("measure", 3'h7);
            wm("back_wait", 3'h6);
            trig <= 1'b0;
        end
        wr_reg(`AOMS_ADDR_CTRL, 8'h00);
        wm("trig_off", 3'h2);
        wr_reg(`AOMS_ADDR_CTRL, 8'h02);
        wm("hibernate", 3'h3);
        rd_chk("hib_read", `AOMS_ADDR_STATUS, 8'h00);
        wake <= ~wake;
        wm("hib_exit", 3'h2);
        rd_chk("aslp_lost", `AOMS_ADDR_ASLP, 8'h00);
        supply <= 1'b0;
        wm("power_off", 3'h0);
        strap <= 1'b1;
        motion <= 1'b1;
        clr_seen <= 1'b1;
        @(posedge clk_in);
        clr_seen <= 1'b0;
        supply <= 1'b1;
        wm("boot_b", 3'h4);
        repeat (5) @(posedge clk_in);
        chk("b_pulse_two", 8'h01, {7'h00, seen2});
        chk("b_pulse_one", 8'h00, {7'h00, seen1});
        rd_chk("stat_b", `AOMS_ADDR_STATUS, stat(3'h4, 1'b1, 1'b1));
        for (i = 0; i < 3; i = i + 1)
            pls(1'b0);
        repeat (3) @(posedge clk_in);
        chk("b_no_sleep", 8'h04, {5'h00, mode});
        wr_reg(`AOMS_ADDR_ASLP, 8'h01);
        pls(1'b0);
        wm("b_sleep", 3'h5);
        pls(1'b1);
        wm("b_wake", 3'h4);
        motion <= 1'b0;
        wm("b_hib", 3'h3);
        motion <= 1'b1;
        wm("b_rewake", 3'h4);
        conclude;
    end
endmodule
